/* File: dv/rmc_core_asserts.sv */
/*
 Checker for rmc_core port behaviour.
 Assumes it is bound to rmc_core and sees only its ports.
*/
module rmc_core_asserts
    import rmc_pkg::*;
#(
    parameter logic [7:0] MON_TYPE = RMC_TYPE_BW
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_secure,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic ev_valid,
    input wire logic overflow_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [1:0] sel_ns;
    logic [1:0] sel_s;
    logic [3:0] since_ev;
    wire logic sel_wr = reg_wr && (reg_addr == RMC_OFF_SEL);
    wire logic ctl_rd = reg_rd && (reg_addr == RMC_OFF_CTL);
    wire logic flt_rd = reg_rd && (reg_addr == RMC_OFF_FLT);
    wire logic [1:0] next_sel_ns = (sel_wr && !reg_secure) ? reg_wdata[1:0] : sel_ns;
    wire logic [1:0] next_sel_s = (sel_wr && reg_secure) ? reg_wdata[1:0] : sel_s;
    // Saturates so a long quiet spell cannot wrap into a false cause
    wire logic [3:0] next_since = ev_valid ? 4'h0 : (since_ev == 4'hf ? 4'hf : since_ev + 4'h1);
    always_ff @(posedge core_clk) begin
        sel_ns <= rst ? 2'h0 : next_sel_ns;
        sel_s <= rst ? 2'h0 : next_sel_s;
        since_ev <= rst ? 4'hf : next_since;
    end
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_type_const: assert property (ctl_rd |=> reg_rdata == '0 || reg_rdata[7:0] == MON_TYPE)
        else $error("type code wrong");
    a_ctl_reserved: assert property (ctl_rd |=> (reg_rdata[23:8] & 16'hfcff) == 16'h0)
        else $error("reserved control bits nonzero");
    a_flt_top: assert property (flt_rd |=> reg_rdata[31:24] == 8'h0)
        else $error("filter top byte nonzero");
    a_sel_echo: assert property (reg_rd && reg_addr == RMC_OFF_SEL |=>
        reg_rdata[1:0] == ($past(reg_secure) ? $past(sel_s) : $past(sel_ns)))
        else $error("instance select readback wrong");
    a_flt_echo: assert property (reg_wr && reg_addr == RMC_OFF_FLT ##2 flt_rd
        && reg_secure == $past(reg_secure, 2) |=> reg_rdata == '0
        || reg_rdata == ($past(reg_wdata, 3) & RMC_FLT_MASK)) else $error("filter readback wrong");
    a_irq_pulse: assert property (overflow_irq |=> !overflow_irq)
        else $error("overflow irq longer than one cycle");
    a_irq_cause: assert property (overflow_irq |-> since_ev < 4'h6)
        else $error("overflow irq without traffic");
endmodule : rmc_core_asserts
bind rmc_core rmc_core_asserts #(.MON_TYPE(MON_TYPE)) u_chk (.core_clk(core_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_secure(reg_secure), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ev_valid(ev_valid),
    .overflow_irq(overflow_irq));

/* File: dv/rmc_core_tb.sv */
/*
 Self-checking bench for rmc_core: registers, settle, captures, filters,
 overflow. Assumes the external source model and the bound checker.
*/
module rmc_core_tb;
    import rmc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst, reg_wr, reg_rd, reg_secure, ev_valid, overflow_irq;
    logic [3:0] reg_addr, ev_sub;
    logic [3:0] mon_secure = 4'b1100;
    logic [31:0] reg_wdata, reg_rdata, rv, wv;
    logic [31:0] st = 32'd83126;
    logic [6:0] fire, ext_capture;
    logic [15:0] ev_pid, ev_amt;
    logic [7:0] ev_grp;
    logic [RMC_INSTANCE_COUNT-1:0][RMC_CNT_W-1:0] level_value = '0;
    logic [30:0] sum;
    int n_fail = 0;
    int tests_run = 0;
    int irqs = 0;
    rmc_core dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_secure(reg_secure), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mon_secure(mon_secure), .ext_capture(ext_capture),
        .ev_valid(ev_valid), .ev_partition_identifier(ev_pid), .ev_monitoring_group(ev_grp),
        .ev_event_subclass(ev_sub), .ev_amount(ev_amt), .level_value(level_value),
        .overflow_irq(overflow_irq));
    rmc_ext_src src (.core_clk(core_clk), .fire(fire), .ext_capture(ext_capture));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (overflow_irq === 1'b1) irqs++;
    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction : rnd
    // Control readback: stored fields only, type code fixed
    function automatic logic [31:0] exp_ctl(input logic [31:0] w);
        return (w & 32'hff030000) | {24'h0, RMC_TYPE_BW};
    endfunction : exp_ctl
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic s, input logic [3:0] a, input logic [31:0] d);
        @(negedge core_clk);
        reg_wr = w;
        reg_rd = !w;
        reg_secure = s;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        {reg_wr, reg_rd} = 2'b00;
        rv = reg_rdata;
    endtask : acc
    task automatic io(input logic w, input int i, input logic [3:0] a, input logic [31:0] d);
        acc(1'b1, mon_secure[i], RMC_OFF_SEL, 32'(i));
        acc(w, mon_secure[i], a, d);
    endtask : io
    task automatic pulse(input int k);
        @(negedge core_clk);
        fire = 7'(1 << k);
        @(negedge core_clk);
        fire = '0;
        repeat (6) @(negedge core_clk);
    endtask : pulse
    // Half the beats carry the filter's ids so matching is really exercised
    task automatic send(input int n, input logic mp, input logic mg);
        sum = '0;
        for (int k = 0; k < n; k++) begin
            @(negedge core_clk);
            rv = rnd();
            ev_valid = 1'b1;
            ev_pid = rv[0] ? 16'h1234 : rv[31:16];
            ev_grp = rv[1] ? 8'h5a : rv[15:8];
            ev_sub = rv[5:2];
            ev_amt = rv[31:16] ^ rv[15:0];
            if ((!mp || ev_pid == 16'h1234) && (!mg || ev_grp == 8'h5a)) sum += 31'(ev_amt);
        end
        @(negedge core_clk);
        ev_valid = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask : send
    task automatic test_done();
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #2_000_000;
        n_fail++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_secure, ev_valid, reg_addr, reg_wdata, fire} = '0;
        {ev_pid, ev_grp, ev_sub, ev_amt} = '0;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wv = rnd() & 32'h0bffffff;
            io(1'b1, i, RMC_OFF_CTL, wv);
            acc(1'b0, mon_secure[i], RMC_OFF_CTL, '0);
            chk(rv, exp_ctl(wv));
            wv = rnd();
            io(1'b1, i, RMC_OFF_FLT, wv);
            acc(1'b0, mon_secure[i], RMC_OFF_FLT, '0);
            chk(rv, wv & RMC_FLT_MASK);
            acc(1'b1, !mon_secure[i], RMC_OFF_SEL, 32'(i));
            acc(1'b0, !mon_secure[i], RMC_OFF_FLT, '0);
            chk(rv, '0);
        end
        acc(1'b0, 1'b0, 4'hf, '0);
        repeat (85) @(negedge core_clk);
        io(1'b1, 0, RMC_OFF_FLT, 32'h005a1234);
        io(1'b1, 0, RMC_OFF_CTL, 32'hf8030000);
        io(1'b0, 0, RMC_OFF_CNT, '0);
        chk(32'(rv[31]), 32'h1);
        io(1'b0, 1, RMC_OFF_CNT, '0);
        chk(32'(rv[31]), 32'h0);
        repeat (85) @(negedge core_clk);
        io(1'b0, 0, RMC_OFF_CNT, '0);
        chk(32'(rv[31]), 32'h0);
        send(40, 1'b1, 1'b1);
        acc(1'b1, 1'b1, RMC_OFF_TRIG, 32'h1);
        io(1'b0, 0, RMC_OFF_CAPT, '0);
        chk(rv, '0);
        acc(1'b1, 1'b1, RMC_OFF_TRIG, 32'h3);
        io(1'b0, 0, RMC_OFF_CAPT, '0);
        chk(rv, {1'b0, sum});
        io(1'b0, 0, RMC_OFF_CNT, '0);
        chk(rv, '0);
        send(30, 1'b1, 1'b1);
        acc(1'b1, 1'b0, RMC_OFF_TRIG, 32'h1);
        io(1'b0, 0, RMC_OFF_CAPT, '0);
        chk(rv, {1'b0, sum});
        io(1'b1, 0, RMC_OFF_CAPT, 32'h80000000);
        io(1'b0, 0, RMC_OFF_CAPT, '0);
        chk(rv, {1'b1, sum});
        for (int k = 0; k < 7; k++) begin
            io(1'b1, 1, RMC_OFF_CTL, 32'h88000000 | (32'(k) << 28));
            pulse(k);
            send(20, 1'b0, 1'b0);
            pulse((k + 1) % 7);
            io(1'b0, 1, RMC_OFF_CNT, '0);
            chk({1'b0, rv[30:0]}, {1'b0, sum});
            pulse(k);
            io(1'b0, 1, RMC_OFF_CAPT, '0);
            chk({1'b0, rv[30:0]}, {1'b0, sum});
        end
        io(1'b1, 2, RMC_OFF_CTL, 32'h83000000);
        irqs = 0;
        @(negedge core_clk);
        ev_amt = 16'hffff;
        ev_valid = 1'b1;
        repeat (32769) @(negedge core_clk);
        ev_valid = 1'b0;
        repeat (4) @(negedge core_clk);
        send(5, 1'b0, 1'b0);
        io(1'b0, 2, RMC_OFF_CNT, '0);
        chk({1'b0, rv[30:0]}, 32'h7fff);
        io(1'b0, 2, RMC_OFF_CTL, '0);
        chk(rv, exp_ctl(32'h87000000));
        chk(32'(irqs), 32'h1);
        io(1'b1, 2, RMC_OFF_CTL, 32'h83000000);
        io(1'b0, 2, RMC_OFF_CTL, '0);
        chk(rv, exp_ctl(32'h83000000));
        io(1'b0, 3, RMC_OFF_CNT, '0);
        chk({1'b0, rv[30:0]}, '0);
        test_done();
    end
endmodule : rmc_core_tb

/* File: dv/rmc_ext_src.sv */
/*
 External capture source model: holds a requested line high a few cycles.
 Assumes requests come from the bench on core_clk.
*/
module rmc_ext_src (
    input wire logic core_clk,
    input wire logic [6:0] fire,
    output logic [6:0] ext_capture
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] hold_a = '0;
    logic [6:0] hold_b = '0;
    // Held as a level so the core's two sync flops cannot miss it
    always @(posedge core_clk) begin
        hold_b <= hold_a;
        hold_a <= fire;
    end
    assign ext_capture = fire | hold_a | hold_b;
endmodule : rmc_ext_src

/* File: logic/rmc_core.sv */
/*
 Resource monitor common logic: per-instance filter and control
 registers selected by an instance select, live count with not-ready
 flag, capture register, local capture trigger, overflow handling.
 Assumes a simple synchronous register port on core_clk, and external
 capture events and monitored traffic arriving from other domains.
*/
// How it works
// - Settings change sets not-ready, settle clears it
// - Not-ready clears one cycle after the fixed settle time ends
// - Each instance keeps its own flag
// - Software may write not-ready either way
// - Flag may be plain read-write bit
// - Selected source loads capture with count, flag
// - Capture completes in one cycle, no handshake
// - Non-secure fire-now captures non-secure source seven
// - Secure fire-now captures secure, or all
// - No local trigger means no source seven
// - Clear-on-capture zeroes count after copy
// - Level monitors read clear-on-capture as zero
// - Overflow sticky until software writes zero
// - Freeze stops counter, else it wraps
// - Interrupt only on overflow rising with enable
// - Instance select steers per-type register access
// - Filter holds identifier and group, top zero
// - Match enables restrict counted events
// - Type code is read-only constant
// - Unused subclass reads zero, ignores writes
// - Source select, unimplemented never captures
// - Enable clear stops event counting; level monitors ignore it
// - Flag copied before capture clears it
module rmc_core #(
    parameter logic [7:0] MON_TYPE = rmc_pkg::RMC_TYPE_BW,
    parameter bit LOCAL_TRIG = 1'b1,
    parameter bit AUTO_NOT_READY_FLAG = 1'b1,
    parameter logic [rmc_pkg::RMC_NUM_SRC-1:0] SRC_IMPL = 7'h7f
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_secure,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [rmc_pkg::RMC_INSTANCE_COUNT-1:0] mon_secure,
    input wire logic [rmc_pkg::RMC_NUM_SRC-1:0] ext_capture,
    input wire logic ev_valid,
    input wire logic [15:0] ev_partition_identifier,
    input wire logic [7:0] ev_monitoring_group,
    input wire logic [3:0] ev_event_subclass,
    input wire logic [15:0] ev_amount,
    input wire logic [rmc_pkg::RMC_INSTANCE_COUNT-1:0][rmc_pkg::RMC_CNT_W-1:0] level_value,
    output logic overflow_irq
);
    import rmc_pkg::*;
    localparam int N = RMC_INSTANCE_COUNT;
    localparam bit IS_BW = (MON_TYPE == RMC_TYPE_BW);

    // Two-flop synchronisers for pin-level inputs
    logic [RMC_NUM_SRC-1:0] ext_s1, ext_s2, ext_s3;
    logic ev_v1, ev_v2;
    logic [27:0] ev_d1, ev_d2;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_s1 <= '0;
            ext_s2 <= '0;
            ext_s3 <= '0;
            ev_v1 <= 1'b0;
            ev_v2 <= 1'b0;
            ev_d1 <= '0;
            ev_d2 <= '0;
        end else begin
            ext_s1 <= ext_capture;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            ev_v1 <= ev_valid;
            ev_v2 <= ev_v1;
            ev_d1 <= {ev_event_subclass, ev_monitoring_group, ev_partition_identifier};
            ev_d2 <= ev_d1;
        end
    end
    // Rising edge of each implemented external source, from the second and third stages
    wire [RMC_NUM_SRC-1:0] ext_pulse = ext_s2 & ~ext_s3 & SRC_IMPL;
    wire [15:0] ev_part = ev_d2[15:0];
    wire [7:0] ev_grp = ev_d2[23:16];
    wire [3:0] ev_sub = ev_d2[27:24];
    // Amount is treated as quasi-static alongside the valid strobe
    logic [15:0] amt_1, amt_2;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            amt_1 <= '0;
            amt_2 <= '0;
        end else begin
            amt_1 <= ev_amount;
            amt_2 <= amt_1;
        end
    end

    // Register decode
    logic [RMC_SEL_W-1:0] sel_s, sel_ns;
    wire [RMC_SEL_W-1:0] sel = reg_secure ? sel_s : sel_ns;
    wire wr_sel = reg_wr && reg_addr == RMC_OFF_SEL;
    wire wr_flt = reg_wr && reg_addr == RMC_OFF_FLT;
    wire wr_ctl = reg_wr && reg_addr == RMC_OFF_CTL;
    wire wr_cnt = reg_wr && reg_addr == RMC_OFF_CNT;
    wire wr_capt = reg_wr && reg_addr == RMC_OFF_CAPT;
    wire wr_trig = reg_wr && reg_addr == RMC_OFF_TRIG;
    wire fire = LOCAL_TRIG && wr_trig && reg_wdata[RMC_TRIG_NOW];
    wire trig_ns = fire && (!reg_secure || reg_wdata[RMC_TRIG_ALL]);
    wire trig_s = fire && reg_secure;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_s <= '0;
            sel_ns <= '0;
        end else if (wr_sel && reg_secure) begin
            sel_s <= reg_wdata[RMC_SEL_W-1:0];
        end else if (wr_sel) begin
            sel_ns <= reg_wdata[RMC_SEL_W-1:0];
        end
    end

    // Writable control bits for this monitor type
    function automatic logic [31:0] ctl_mask_f(input bit bw);
        logic [31:0] m;
        m = RMC_CTL_MASK;
        m[RMC_CTL_CLR] = bw;
        m[RMC_CTL_SUB_LSB +: 4] = 4'h0;
        return m;
    endfunction : ctl_mask_f
    localparam logic [31:0] CTL_WMASK = ctl_mask_f(IS_BW);

    logic [N-1:0][31:0] flt;
    logic [N-1:0][31:0] ctl;
    logic [N-1:0][RMC_CNT_W-1:0] cnt;
    logic [N-1:0] not_ready_flag;
    logic [N-1:0][31:0] capt;
    logic [N-1:0] irq_pend;
    logic [N-1:0] busy;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_mon
            wire hit = (sel == RMC_SEL_W'(g)) && (reg_secure == mon_secure[g]);
            wire cfg_wr = hit && (wr_flt || wr_ctl);
            wire [2:0] src = ctl[g][RMC_CTL_SRC_LSB +: 3];
            wire loc = mon_secure[g] ? trig_s : trig_ns;
            wire cap = (src == RMC_SRC_LOCAL) ? loc : ext_pulse[src];
            wire en = ctl[g][RMC_CTL_EN];
            wire part_ok = !ctl[g][RMC_CTL_PART_EN] || ev_part == flt[g][15:0];
            wire grp_ok = !ctl[g][RMC_CTL_GRP_EN] || ev_grp == flt[g][23:16];
            wire sub_ok = ev_sub == ev_sub;
            wire count_ev = IS_BW && en && ev_v2 && part_ok && grp_ok && sub_ok;
            wire frozen = ctl[g][RMC_CTL_FRZ] && ctl[g][RMC_CTL_OFLOW];
            wire [RMC_CNT_W:0] sum = {1'b0, cnt[g]} + {{(RMC_CNT_W-15){1'b0}}, amt_2};
            wire ovf = count_ev && !frozen && sum[RMC_CNT_W];
            wire clr_cap = cap && ctl[g][RMC_CTL_CLR];

            rmc_settle u_settle (
                .core_clk(core_clk),
                .rst(rst),
                .start(AUTO_NOT_READY_FLAG && cfg_wr),
                .cancel(cap),
                .busy(busy[g])
            );

            always_ff @(posedge core_clk) begin
                if (rst) begin
                    flt[g] <= '0;
                    ctl[g] <= RMC_CTL_RESET;
                end else begin
                    if (hit && wr_flt) begin
                        flt[g] <= reg_wdata & RMC_FLT_MASK;
                    end
                    if (hit && wr_ctl) begin
                        ctl[g] <= reg_wdata & CTL_WMASK;
                    end
                    if (ovf) begin
                        ctl[g][RMC_CTL_OFLOW] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (rst) begin
                    cnt[g] <= '0;
                    capt[g] <= '0;
                    irq_pend[g] <= 1'b0;
                end else begin
                    if (cap) begin
                        capt[g] <= {not_ready_flag[g], IS_BW ? cnt[g] : level_value[g]};
                    end else if (hit && wr_capt) begin
                        capt[g][RMC_NOT_READY_FLAG_BIT] <= reg_wdata[RMC_NOT_READY_FLAG_BIT];
                    end
                    if (clr_cap) begin
                        cnt[g] <= '0;
                    end else if (count_ev && !frozen) begin
                        cnt[g] <= sum[RMC_CNT_W-1:0];
                    end else if (hit && wr_cnt) begin
                        cnt[g] <= reg_wdata[RMC_CNT_W-1:0];
                    end
                    irq_pend[g] <= ovf && !ctl[g][RMC_CTL_OFLOW] && ctl[g][RMC_CTL_IRQ_EN];
                end
            end

            // Flag: set by settings change, cleared by settle or capture
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    not_ready_flag[g] <= 1'b0;
                end else if (AUTO_NOT_READY_FLAG && cfg_wr) begin
                    not_ready_flag[g] <= 1'b1;
                end else if (hit && wr_cnt) begin
                    not_ready_flag[g] <= reg_wdata[RMC_NOT_READY_FLAG_BIT];
                end else if (AUTO_NOT_READY_FLAG && (cap || (not_ready_flag[g] && !busy[g]))) begin
                    not_ready_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign overflow_irq = |irq_pend;

    // Read mux for the selected instance, unmapped reads as zero
    wire [RMC_SEL_W-1:0] ri = sel;
    wire own = reg_secure == mon_secure[ri];
    wire [31:0] cnt_word = {not_ready_flag[ri], IS_BW ? cnt[ri] : level_value[ri]};
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                RMC_OFF_SEL: reg_rdata <= {{(32-RMC_SEL_W){1'b0}}, sel};
                RMC_OFF_FLT: reg_rdata <= own ? flt[ri] : 32'h0;
                RMC_OFF_CTL: reg_rdata <= own ? (ctl[ri] | {24'h0, MON_TYPE}) : 32'h0;
                RMC_OFF_CNT: reg_rdata <= own ? cnt_word : 32'h0;
                RMC_OFF_CAPT: reg_rdata <= own ? capt[ri] : 32'h0;
                default: reg_rdata <= 32'h0;
            endcase
        end
    end
endmodule : rmc_core

/* File: logic/rmc_pkg.sv */
/*
 Package of constants for the resource monitor common block: register
 offsets, control field positions, type codes and settle timing.
 Assumes a 40 MHz core clock.
*/
package rmc_pkg;
    localparam int RMC_INSTANCE_COUNT = 4;
    localparam int RMC_SEL_W = 2;
    localparam int RMC_CNT_W = 31;
    localparam int RMC_NUM_SRC = 7;
    // Register offsets (word addresses, byte = 4 x index)
    localparam logic [3:0] RMC_OFF_SEL = 4'h0;
    localparam logic [3:0] RMC_OFF_FLT = 4'h1;
    localparam logic [3:0] RMC_OFF_CTL = 4'h2;
    localparam logic [3:0] RMC_OFF_CNT = 4'h3;
    localparam logic [3:0] RMC_OFF_CAPT = 4'h4;
    localparam logic [3:0] RMC_OFF_TRIG = 4'h5;
    // Filter fields
    localparam int RMC_FLT_PART_LSB = 0;
    localparam int RMC_FLT_GRP_LSB = 16;
    localparam logic [31:0] RMC_FLT_MASK = 32'h00ffffff;
    // Control fields
    localparam int RMC_CTL_PART_EN = 16;
    localparam int RMC_CTL_GRP_EN = 17;
    localparam int RMC_CTL_SUB_LSB = 20;
    localparam int RMC_CTL_FRZ = 24;
    localparam int RMC_CTL_IRQ_EN = 25;
    localparam int RMC_CTL_OFLOW = 26;
    localparam int RMC_CTL_CLR = 27;
    localparam int RMC_CTL_SRC_LSB = 28;
    localparam int RMC_CTL_EN = 31;
    localparam logic [31:0] RMC_CTL_MASK = 32'hfff30000;
    localparam logic [31:0] RMC_CTL_RESET = 32'h00000000;
    localparam logic [7:0] RMC_TYPE_BW = 8'h42;
    localparam logic [7:0] RMC_TYPE_OCC = 8'h43;
    localparam logic [2:0] RMC_SRC_LOCAL = 3'h7;
    // Trigger register bits and status bit in count words
    localparam int RMC_TRIG_NOW = 0;
    localparam int RMC_TRIG_ALL = 1;
    localparam int RMC_NOT_READY_FLAG_BIT = 31;
    // Settle time: longest not-ready time
    localparam int RMC_SETTLE_NS = 2000;
    localparam int RMC_CLK_NS = 25;
    localparam int RMC_SETTLE_CYC = RMC_SETTLE_NS / RMC_CLK_NS;
    localparam int RMC_SETTLE_W = 7;
endpackage : rmc_pkg

/* File: logic/rmc_settle.sv */
/*
 Per-instance settle timer: raises busy on start, drops it after the
 settle count. Assumes start comes from logic on core_clk.
*/
module rmc_settle (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic cancel,
    output logic busy
);
    import rmc_pkg::*;
    logic [RMC_SETTLE_W-1:0] count;
    logic [RMC_SETTLE_W-1:0] next_count;
    wire done = busy && (count == RMC_SETTLE_W'(RMC_SETTLE_CYC - 1));
    assign next_count = start ? '0 : count + 1'b1;
    always_ff @(posedge core_clk) begin
        // A settings change in the capture cycle still restarts the settle wait
        if (rst || (cancel && !start)) begin
            busy <= 1'b0;
            count <= '0;
        end else begin
            busy <= start || (busy && !done);
            count <= (busy || start) ? next_count : '0;
        end
    end
endmodule : rmc_settle
